// [flash_status_core.sv]
// Status register, write enable latch and serial status readout
//
// Operation
// - Latch-clear command clears latch, refuses writes
// - Latch clears on power-up and completions
// - Small-sector erase only in uniform variant
// - Status read accepted at any time
// - Status byte repeats until chip select rises
// - Status byte bit layout fixed
// - Busy bit driven internally, read-only
// - Latch gates register-write, program, erase
// - Only latch-set command sets latch
// - Protect bits written, volatility by config
// - Protect bits block writes to region
// - Full erase only with protect bits zero
// - Protect bits default to zero
// - Erase failure sets sticky erase flag
// - Program failure sets sticky program flag
// - Lock bit plus low pin locks registers
// - Protected attempts leave error flags alone
// - Config read shifts config byte out
// - Config byte starts at zero
// - Latch-set command sets latch only when idle, ignored while busy
// - Four-lane mode disables hardware lock
`timescale 1ns/1ps
module flash_status_core
  import flash_status_pkg::*;
#(
  parameter logic [7:0] OP_LATCH_CLEAR = OP_LATCH_CLEAR_DEF,
  parameter logic [7:0] OP_LATCH_SET = OP_LATCH_SET_DEF,
  parameter logic [7:0] OP_STATUS_READ = OP_STATUS_READ_DEF,
  parameter logic [7:0] OP_CONFIG_READ = OP_CONFIG_READ_DEF,
  parameter logic [7:0] OP_REG_WRITE = OP_REG_WRITE_DEF,
  parameter logic [7:0] OP_ERR_CLEAR = OP_ERR_CLEAR_DEF,
  parameter bit UNIFORM_64K = 1'b1
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  input wire logic write_protect_n_pin_in,
  output logic so_out,
  output logic so_oe_out,
  input wire logic array_req_in,
  input wire array_kind_t array_kind_in,
  input wire logic array_protected_in,
  input wire logic array_done_in,
  input wire logic array_fail_in,
  output logic array_go_out,
  output logic array_refuse_out,
  output logic [7:0] status_out,
  output logic [7:0] config_out,
  output logic hw_lock_out
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_meta_reg;
  logic rst_s;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_reg <= 1'b0;
      rst_s <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_s <= rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  core_t core_reg;
  core_t core_next;
  link_t link_reg;
  link_t link_next;
  fall_t fall_reg;
  fall_t fall_next;
  logic armed_reg;
  logic [2:0] core_sync;
  logic req_s, cs_s, wp_n_s, ack_s, cs_rise, hw_lock;
  logic [2:0] bp_eff;
  logic [7:0] status_live;
  logic cmd8, regwr_ok, arr_prot, arr_legal, arr_ok, rd_mode;
  logic [7:0] rd_byte;
  frame_t f;

  ////////////////////////////////////////////////////////////////////////
  // Crossings
  level_sync #(.WIDTH(3)) core_sync_u (
    .clk_in(clk_in),
    .rst_b_in(rst_s),
    .d_in({cs_n_in, write_protect_n_pin_in, link_reg.req_seen}),
    .q_out(core_sync)
  );
  level_sync #(.WIDTH(1)) link_sync_u (
    .clk_in(sck_in),
    .rst_b_in(rst_s),
    .d_in(core_reg.req),
    .q_out(req_s)
  );
  assign cs_s = core_sync[2];
  assign wp_n_s = core_sync[1];
  assign ack_s = core_sync[0];

  ////////////////////////////////////////////////////////////////////////
  // Link, rising edge: collect command and data bits
  // First edge of a frame is marked by this flag, cleared at deselect
  always_ff @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= 1'b1;
    end
  end
  always_comb begin
    link_next = link_reg;
    if (!armed_reg) begin
      link_next.frame.cnt = 5'h01;
      link_next.frame.cmd = {7'h00, si_in};
      link_next.frame.data = 16'h0000;
    end else begin
      if (link_reg.frame.cnt != FRAME_CNT_MAX) begin
        link_next.frame.cnt = link_reg.frame.cnt + 5'h01;
      end
      if (link_reg.frame.cnt < FRAME_CMD_BITS) begin
        link_next.frame.cmd = {link_reg.frame.cmd[6:0], si_in};
      end else begin
        link_next.frame.data = {link_reg.frame.data[14:0], si_in};
      end
    end
    // Take a fresh snapshot of the register pair when offered
    if (req_s != link_reg.req_seen) begin
      link_next.req_seen = req_s;
      link_next.copy = core_reg.pub;
    end
  end

  always_ff @(posedge sck_in or negedge rst_s) begin
    if (!rst_s) begin
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link, falling edge: shift status or config out
  assign rd_mode = (link_reg.frame.cnt >= FRAME_CMD_BITS) &&
    ((link_reg.frame.cmd == OP_STATUS_READ) ||
     (link_reg.frame.cmd == OP_CONFIG_READ));
  assign rd_byte = (link_reg.frame.cmd == OP_STATUS_READ) ?
    link_reg.copy.status : link_reg.copy.cfg;
  always_comb begin
    fall_next = fall_reg;
    if (rd_mode) begin
      fall_next.active = 1'b1;
      fall_next.bitn = fall_reg.bitn + 3'h1;
      if (fall_reg.bitn == 3'h0) begin
        fall_next.so = rd_byte[7];
        fall_next.sh = {rd_byte[6:0], 1'b0};
      end else begin
        fall_next.so = fall_reg.sh[7];
        fall_next.sh = {fall_reg.sh[6:0], 1'b0};
      end
    end
  end
  // Deselect ends the readout at once, without any clock edge
  always_ff @(negedge sck_in or posedge cs_n_in or negedge rst_s) begin
    if (!rst_s) begin
      fall_reg <= '0;
    end else if (cs_n_in) begin
      fall_reg <= '0;
    end else begin
      fall_reg <= fall_next;
    end
  end

  assign so_out = fall_reg.so;
  assign so_oe_out = fall_reg.active;

  ////////////////////////////////////////////////////////////////////////
  // Core: command execution
  // Frame is quiet once deselect has been seen here
  assign f = link_reg.frame;
  assign cs_rise = cs_s && !core_reg.cs_prev;
  assign cmd8 = cs_rise && (f.cnt == FRAME_CMD_BITS);
  assign hw_lock = core_reg.lock && !wp_n_s &&
    !core_reg.cfg[CFG_QUAD_BIT];
  assign bp_eff = core_reg.cfg[CFG_BP_NONVOL_BIT] ?
    core_reg.bp_nv : core_reg.bp_vol;
  assign regwr_ok = cs_rise && (f.cmd == OP_REG_WRITE) &&
    ((f.cnt == FRAME_REGWR_SHORT) || (f.cnt == FRAME_REGWR_LONG)) &&
    core_reg.latch && !hw_lock && (core_reg.state == ST_IDLE);
  assign arr_prot =
    ((array_kind_in <= K_SECTOR) && array_protected_in) ||
    ((array_kind_in == K_FULL) && (bp_eff != 3'h0));
  assign arr_legal = (array_kind_in <= K_OTP) &&
    ((array_kind_in != K_SMALL) || UNIFORM_64K);
  assign arr_ok = array_req_in && (core_reg.state == ST_IDLE) &&
    core_reg.latch && arr_legal && !arr_prot;
  assign status_live = {core_reg.lock, core_reg.perr, core_reg.eerr,
    bp_eff, core_reg.latch, core_reg.state != ST_IDLE};
  always_comb begin
    logic [7:0] wr_stat;
    wr_stat = (f.cnt == FRAME_REGWR_LONG) ? f.data[15:8] : f.data[7:0];
    core_next = core_reg;
    core_next.go = 1'b0;
    core_next.refuse = 1'b0;
    core_next.cs_prev = cs_s;
    if (cmd8 && (f.cmd == OP_LATCH_CLEAR)) begin
      core_next.latch = 1'b0;
    end
    if (cmd8 && (f.cmd == OP_LATCH_SET) &&
        (core_reg.state == ST_IDLE)) begin
      core_next.latch = 1'b1;
    end
    if (cmd8 && (f.cmd == OP_ERR_CLEAR)) begin
      core_next.perr = 1'b0;
      core_next.eerr = 1'b0;
    end
    if (regwr_ok) begin
      core_next.lock = wr_stat[ST_LOCK_BIT];
      if (core_reg.cfg[CFG_BP_NONVOL_BIT]) begin
        core_next.bp_nv = wr_stat[ST_BP_HI:ST_BP_LO];
      end else begin
        core_next.bp_vol = wr_stat[ST_BP_HI:ST_BP_LO];
      end
      if (f.cnt == FRAME_REGWR_LONG) begin
        core_next.cfg = (core_reg.cfg & ~CFG_WRITABLE) |
          (f.data[7:0] & CFG_WRITABLE);
      end
      core_next.state = ST_REG;
      core_next.timer = REGWR_CYCLES;
    end
    if (array_req_in) begin
      if (arr_ok) begin
        core_next.go = 1'b1;
        core_next.state = ST_ARRAY;
        core_next.kind = array_kind_in;
      end else begin
        core_next.refuse = 1'b1;
      end
    end
    // Completions come last so a failure beats a same-cycle clear
    case (core_reg.state)
      ST_IDLE: begin
      end
      ST_REG: begin
        core_next.timer = core_reg.timer - 5'h01;
        if (core_reg.timer == 5'h01) begin
          core_next.state = ST_IDLE;
          core_next.latch = 1'b0;
        end
      end
      ST_ARRAY: begin
        if (array_done_in) begin
          core_next.state = ST_IDLE;
          if (core_reg.kind != K_SMALL || UNIFORM_64K) begin
            core_next.latch = 1'b0;
          end
          if (array_fail_in) begin
            if ((core_reg.kind == K_SMALL) ||
                (core_reg.kind == K_SECTOR) ||
                (core_reg.kind == K_FULL)) begin
              core_next.eerr = 1'b1;
            end else begin
              core_next.perr = 1'b1;
            end
          end
        end
      end
      default: begin
        core_next.state = ST_IDLE;
      end
    endcase
    // Offer a new register snapshot to the link once the last is taken
    if ((ack_s == core_reg.req) &&
        ({status_live, core_reg.cfg} != core_reg.pub)) begin
      core_next.pub = {status_live, core_reg.cfg};
      core_next.req = !core_reg.req;
    end
  end

  always_ff @(posedge clk_in or negedge rst_s) begin
    if (!rst_s) begin
      core_reg <= '0;
      core_reg.state <= ST_IDLE;
      core_reg.kind <= K_PAGE;
      core_reg.latch <= 1'b0;
      core_reg.bp_nv <= BP_RESET;
      core_reg.bp_vol <= BP_RESET;
      core_reg.cfg <= CONFIG_RESET;
    end else begin
      core_reg <= core_next;
    end
  end

  assign array_go_out = core_reg.go;
  assign array_refuse_out = core_reg.refuse;
  assign status_out = status_live;
  assign config_out = core_reg.cfg;
  assign hw_lock_out = hw_lock;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  latch_clear_a: assert property (
    @(posedge clk_in) disable iff (!rst_s)
    cmd8 && (f.cmd == OP_LATCH_CLEAR) |=> !core_reg.latch)
    else $error("Latch not cleared by latch-clear command");
  latch_set_a: assert property (
    @(posedge clk_in) disable iff (!rst_s)
    cmd8 && (f.cmd == OP_LATCH_SET) && (core_reg.state == ST_IDLE)
    |=> core_reg.latch [*2])
    else $error("Latch not set by latch-set command");
  latch_source_a: assert property (
    @(posedge clk_in) disable iff (!rst_s)
    $rose(core_reg.latch) |-> $past(cmd8) &&
      ($past(f.cmd) == OP_LATCH_SET))
    else $error("Latch set without latch-set command");
  no_latch_a: assert property (
    @(posedge clk_in) disable iff (!rst_s)
    array_req_in && !core_reg.latch |=> array_refuse_out && !array_go_out)
    else $error("Array operation granted with latch clear");
  full_wipe_a: assert property (
    @(posedge clk_in) disable iff (!rst_s)
    array_req_in && (array_kind_in == K_FULL) && (bp_eff != 3'h0)
    |=> !array_go_out)
    else $error("Full erase granted with protect bits set");
  region_prot_a: assert property (
    @(posedge clk_in) disable iff (!rst_s)
    array_req_in && array_protected_in && (array_kind_in <= K_SECTOR)
    |=> !array_go_out ##1 (!core_reg.perr || $past(core_reg.perr, 2)))
    else $error("Protected region operation granted");
  regwr_cycle_a: assert property (
    @(posedge clk_in) disable iff (!rst_s)
    $rose(core_reg.state == ST_REG) |-> core_reg.timer == REGWR_CYCLES
      ##24 (core_reg.state == ST_REG) ##1
      (core_reg.state == ST_IDLE) && !core_reg.latch)
    else $error("Register write cycle length or latch clear wrong");
  busy_bit_a: assert property (
    @(posedge clk_in) disable iff (!rst_s)
    array_go_out |-> status_out[ST_BUSY_BIT] ##1
      (status_out[ST_BUSY_BIT] || $past(array_done_in)))
    else $error("Busy bit low during array operation");
  erase_err_a: assert property (
    @(posedge clk_in) disable iff (!rst_s)
    (core_reg.state == ST_ARRAY) && array_done_in && array_fail_in &&
      (core_reg.kind == K_SECTOR) |=> core_reg.eerr)
    else $error("Erase failure not flagged");
  hw_lock_a: assert property (
    @(posedge clk_in) disable iff (!rst_s)
    hw_lock && cs_rise |=> $stable(core_reg.lock) &&
      $stable(core_reg.bp_nv) && $stable(core_reg.cfg))
    else $error("Locked registers changed");
  quad_lock_a: assert property (
    @(posedge clk_in) disable iff (!rst_s)
    core_reg.cfg[CFG_QUAD_BIT] |-> !hw_lock_out)
    else $error("Hardware lock active in four-lane mode");
endmodule

// [flash_status_pkg.sv]
// Shared constants and types for the flash status and latch block
package flash_status_pkg;

  // Default command opcodes (arbitrary plain values)
  localparam logic [7:0] OP_LATCH_CLEAR_DEF = 8'h14;
  localparam logic [7:0] OP_LATCH_SET_DEF = 8'h16;
  localparam logic [7:0] OP_STATUS_READ_DEF = 8'h15;
  localparam logic [7:0] OP_CONFIG_READ_DEF = 8'h45;
  localparam logic [7:0] OP_REG_WRITE_DEF = 8'h11;
  localparam logic [7:0] OP_ERR_CLEAR_DEF = 8'h40;

  // Frame lengths in serial bits, and the limit at which the bit counter stops
  localparam logic [4:0] FRAME_CMD_BITS = 5'h08;
  localparam logic [4:0] FRAME_REGWR_SHORT = 5'h10;
  localparam logic [4:0] FRAME_REGWR_LONG = 5'h18;
  localparam logic [4:0] FRAME_CNT_MAX = 5'h1f;

  // Status byte layout
  localparam int ST_LOCK_BIT = 7;
  localparam int ST_PERR_BIT = 6;
  localparam int ST_EERR_BIT = 5;
  localparam int ST_BP_HI = 4;
  localparam int ST_BP_LO = 2;
  localparam int ST_LATCH_BIT = 1;
  localparam int ST_BUSY_BIT = 0;

  // Configuration byte layout
  localparam int CFG_QUAD_BIT = 1;
  localparam int CFG_TOP_PARAM_BIT = 2;
  localparam int CFG_BP_NONVOL_BIT = 3;
  localparam int CFG_PROT_TOP_BIT = 5;
  localparam logic [7:0] CFG_WRITABLE = 8'h2e;

  // Values after reset
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [2:0] BP_RESET = 3'h0;

  // Self-timed register write cycle
  localparam int CLK_PERIOD_NS = 40;
  localparam int REGWR_TIME_NS = 1000;
  localparam logic [4:0] REGWR_CYCLES =
    5'((REGWR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REG = 2'b01,
    ST_ARRAY = 2'b10
  } core_state_t;

  typedef enum logic [2:0] {
    K_PAGE = 3'b000,
    K_QUAD_PAGE = 3'b001,
    K_SMALL = 3'b010,
    K_SECTOR = 3'b011,
    K_FULL = 3'b100,
    K_OTP = 3'b101
  } array_kind_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] cfg;
  } reg_pair_t;

  typedef struct packed {
    logic [4:0] cnt;
    logic [7:0] cmd;
    logic [15:0] data;
  } frame_t;

  typedef struct packed {
    frame_t frame;
    logic req_seen;
    reg_pair_t copy;
  } link_t;

  typedef struct packed {
    logic active;
    logic [2:0] bitn;
    logic [7:0] sh;
    logic so;
  } fall_t;

  typedef struct packed {
    core_state_t state;
    logic [4:0] timer;
    array_kind_t kind;
    logic latch;
    logic lock;
    logic [2:0] bp_nv;
    logic [2:0] bp_vol;
    logic perr;
    logic eerr;
    logic [7:0] cfg;
    logic cs_prev;
    logic go;
    logic refuse;
    reg_pair_t pub;
    logic req;
  } core_t;

endpackage

// [level_sync.sv]
// Two flip-flop level synchroniser, one chain per bit
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_reg;
      logic hold_reg;
      always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          meta_reg <= 1'b0;
          hold_reg <= 1'b0;
        end else begin
          meta_reg <= d_in[i];
          hold_reg <= meta_reg;
        end
      end
      assign q_out[i] = hold_reg;
    end
  endgenerate
endmodule

// [host_spi_model.sv]
// Host serial controller model for the flash status link
`timescale 1ns/1ps
module host_spi_model (
  output logic sck_out,
  output logic cs_n_out,
  output logic si_out,
  input wire logic so_in,
  output logic [7:0] rd_byte_out,
  output logic rd_done_out
);
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b1;
    rd_byte_out = 8'h00;
    rd_done_out = 1'b0;
  end
  ////////////////////////////////////////
  // One framed transfer, 64 ns link period, clock still between frames
  task automatic frame(input logic [23:0] d, input int n, input int nrd);
    int i;
    #7;
    cs_n_out = 1'b0;
    for (i = n - 1; i >= 0; i--) begin
      si_out = d[i];
      #32 sck_out = 1'b1;
      #32 sck_out = 1'b0;
    end
    si_out = ~si_out;
    for (i = 0; i < nrd * 8; i++) begin
      #32 sck_out = 1'b1;
      rd_byte_out = {rd_byte_out[6:0], so_in};
      rd_done_out = (i % 8 == 7);
      #32 sck_out = 1'b0;
      rd_done_out = 1'b0;
    end
    #32 cs_n_out = 1'b1;
    #200;
  endtask
endmodule

// [tb.sv]
// Self-checking bench for the status and latch block
`timescale 1ns/1ps
module tb;
  import flash_status_pkg::*;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic wp_n = 1'b1;
  logic req = 1'b0;
  array_kind_t kind = K_PAGE;
  logic prot = 1'b0;
  logic done = 1'b0;
  logic fail = 1'b0;
  logic sck, cs_n, si, so, so_oe, go, refuse, hw_lock, rd_done;
  logic [7:0] st, cfg, rd_byte, exp_st;
  logic exp_res_q[$];
  logic [7:0] exp_rd_q[$];
  int err_count = 0;
  int checks_done = 0;
  int k;
  logic f;

  always #20 clk_in = ~clk_in;

  host_spi_model host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si),
    .so_in(so), .rd_byte_out(rd_byte), .rd_done_out(rd_done));

  flash_status_core uut (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
    .write_protect_n_pin_in(wp_n), .so_out(so), .so_oe_out(so_oe),
    .array_req_in(req), .array_kind_in(kind), .array_protected_in(prot),
    .array_done_in(done), .array_fail_in(fail), .array_go_out(go),
    .array_refuse_out(refuse), .status_out(st), .config_out(cfg),
    .hw_lock_out(hw_lock));

  ////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Array answers and serial bytes, oldest note first
  always @(posedge clk_in) begin
    if (go === 1'b1 || refuse === 1'b1) begin
      if (exp_res_q.size() == 0) check("array answer", 8'h00, 8'h01);
      else check("array grant", {7'h0, exp_res_q.pop_front()}, {7'h0, go});
    end
  end

  always @(posedge rd_done) begin
    check("so_oe_out", 8'h01, {7'h0, so_oe});
    if (exp_rd_q.size() == 0) check("serial byte", 8'h00, 8'hff);
    else check("serial byte", exp_rd_q.pop_front(), rd_byte);
  end

  task automatic cmd(input logic [7:0] op);
    host.frame({16'h0, op}, 8, 0);
  endtask

  task automatic chk_st(input int n);
    repeat (n) exp_rd_q.push_back(exp_st);
    host.frame({16'h0, OP_STATUS_READ_DEF}, 8, n);
    check("status_out", exp_st, st);
    check("so_oe_out", 8'h00, {7'h0, so_oe});
  endtask

  task automatic reg_wr(input logic [7:0] d);
    host.frame({8'h0, OP_REG_WRITE_DEF, d}, 16, 0);
    repeat (30) @(posedge clk_in);
  endtask

  task automatic arr(input array_kind_t kd, input logic p, input logic ok);
    @(posedge clk_in);
    req <= 1'b1;
    kind <= kd;
    prot <= p;
    exp_res_q.push_back(ok);
    @(posedge clk_in);
    req <= 1'b0;
    repeat (5) @(posedge clk_in);
  endtask

  task automatic finish_op(input logic fl);
    @(posedge clk_in);
    done <= 1'b1;
    fail <= fl;
    @(posedge clk_in);
    done <= 1'b0;
    fail <= 1'b0;
    repeat (5) @(posedge clk_in);
  endtask

  ////////////////////////////////////////
  initial begin
    #300000;
    err_count++;
    end_of_test();
  end

  initial begin
    void'($urandom(73));
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    exp_st = 8'h00;
    chk_st(2);
    check("config_out", CONFIG_RESET, cfg);
    arr(K_PAGE, 1'b0, 1'b0);
    cmd(OP_LATCH_SET_DEF);
    exp_st = 8'h02;
    chk_st(1);
    cmd(OP_LATCH_CLEAR_DEF);
    exp_st = 8'h00;
    chk_st(1);
    arr(K_SECTOR, 1'b0, 1'b0);
    for (k = 0; k < 6; k++) begin
      f = (k == 0 || k == 4) ? 1'b1 : 1'($urandom_range(1));
      cmd(OP_LATCH_SET_DEF);
      arr(array_kind_t'(k), 1'b0, 1'b1);
      exp_st[1:0] = 2'h3;
      chk_st(1);
      finish_op(f);
      exp_st[1:0] = 2'h0;
      if (f && k >= 2 && k <= 4) exp_st[5] = 1'b1;
      else if (f) exp_st[6] = 1'b1;
      chk_st(1);
    end
    cmd(OP_LATCH_SET_DEF);
    arr(K_PAGE, 1'b1, 1'b0);
    exp_st[1] = 1'b1;
    chk_st(1);
    cmd(OP_ERR_CLEAR_DEF);
    exp_st[6:5] = 2'h0;
    chk_st(1);
    reg_wr(8'h16);
    exp_st = 8'h14;
    chk_st(1);
    cmd(OP_LATCH_SET_DEF);
    arr(K_FULL, 1'b0, 1'b0);
    arr(array_kind_t'(3'h6), 1'b0, 1'b0);
    exp_st = 8'h16;
    chk_st(1);
    reg_wr(8'h80);
    exp_st = 8'h80;
    chk_st(1);
    wp_n <= 1'b0;
    repeat (6) @(posedge clk_in);
    check("hw_lock_out", 8'h01, {7'h0, hw_lock});
    cmd(OP_LATCH_SET_DEF);
    reg_wr(8'h00);
    exp_st = 8'h82;
    chk_st(1);
    wp_n <= 1'b1;
    repeat (6) @(posedge clk_in);
    host.frame({OP_REG_WRITE_DEF, 8'h80, 8'h02}, 24, 0);
    repeat (30) @(posedge clk_in);
    exp_st = 8'h80;
    chk_st(1);
    check("config_out", 8'h02, cfg);
    exp_rd_q.push_back(8'h02);
    exp_rd_q.push_back(8'h02);
    host.frame({16'h0, OP_CONFIG_READ_DEF}, 8, 2);
    wp_n <= 1'b0;
    repeat (6) @(posedge clk_in);
    check("hw_lock_out", 8'h00, {7'h0, hw_lock});
    check("array queue", 8'h00, 8'(exp_res_q.size()));
    check("serial queue", 8'h00, 8'(exp_rd_q.size()));
    end_of_test();
  end
endmodule
